// *** design/dcpe_engine.sv ***
// Disk command protocol engine: host-facing port logic, parameter store,
// command decode and error report. Host reaches it over a strobed port.
// What this block does
// - Keep sixteen parameter bytes until hardware or software reset, then drop them.
// - Parameter block order: vector, options, drives, cylinders, heads, block size.
// - Option bit 0 selects deblocking; bit 1 selects logical track addressing.
// - Option bit 2 selects 24-bit block when bit 1 is set; bit 3 verify; bits 4-7 zero.
// - Command bytes, interrupt, then device raises request which host clears.
// - Data phase only for data commands without error, ending in request.
// - On error host interrupts and reads error bytes; final interrupt ends command.
// - Codes 00, 01, 02 park, rezero, or only clear buffers.
// - Command 04 takes three bytes; data phase must confirm with YES.
// - Read 08 takes seven bytes, option bits flush and forget.
// - Write 0A uses same layout; host supplies block bytes in data phase.
// - Physical addressing decodes drive, cylinder, head and block number.
// - Logical track: upper nibble drive, lower nibble block MSBs, then bytes.
// - Logical drive: 24-bit block including drive; numbering starts at zero.
// - On error return thirteen error bytes in status phase.
// - Error byte 0 flags fatal, host, init, option, command, confirm, address; the address flag is never set.
// - Error byte 1 holds media error flags from drive side.
// - Error byte 2 holds drive error flags; byte 3 unused.
// - Sector 512 bytes, 16 per track, fill E5 and B6, 10 retries.
// - Status: error bit 4, ready 5, busy 6, request 7.
// - Four ports: status/reset, FIFO, interrupt, request clear.
//
// Implementation choices: the register offsets and the address-and-strobe port.
`timescale 1ns/10ps
module dcpe_engine
  import dcpe_pkg::*;
#(
  parameter int BLOCK_BYTES = SECTOR_BYTES
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic rstn,
  // Host port
  input wire logic [1:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [7:0] rdata,
  // Decoded command towards the drive logic
  output logic [7:0] cmd_code,
  output logic cmd_go,
  output logic [7:0] cmd_opts,
  output logic [7:0] op_drive,
  output logic [15:0] op_cyl,
  output logic [7:0] op_head,
  output logic [23:0] op_block,
  output logic [7:0] mode_opts,
  output logic wdata_vld,
  output logic [7:0] wdata_out,
  // Media and drive error flags and read data bytes from the drive logic
  input wire logic [7:0] media_err,
  input wire logic [7:0] drive_err,
  input wire logic [7:0] rdata_in
);
  // A logical block never spans more than one physical sector
  initial begin
    if (BLOCK_BYTES < 1 || BLOCK_BYTES > SECTOR_BYTES) $error("BLOCK_BYTES out of range");
  end

  dcpe_state_e state_r;
  logic [7:0] param_r [PARAM_BYTES];
  logic [7:0] cmd_r [CMD_MAX_BYTES];
  logic [7:0] err_r [ERR_BYTES];
  logic [3:0] cnt_r;
  logic [15:0] dcnt_r;
  logic busy_r, rdy_r, req_r, error_r, inited_r;
  logic [1:0] conf_r;
  logic conf_ok_r;

  wire soft_rst = wr && addr == PORT_STATUS;
  wire kick = wr && addr == PORT_KICK;
  wire fifo_wr = wr && addr == PORT_FIFO;
  wire fifo_rd = rd && addr == PORT_FIFO;

  function automatic logic has_data(input logic [7:0] c);
    has_data = c == CMD_ALLTRK || c == CMD_READ || c == CMD_WRITE;
  endfunction

  // Reserved option bits or a drive count outside one to two
  function automatic logic params_bad(input logic [7:0] opt, input logic [7:0] drives);
    params_bad = (opt & OPT_RSVD_MASK) != 8'h00 || drives < 8'h01 || drives > 8'h02;
  endfunction

  // Validation of the stored command
  logic [7:0] e0;
  always_comb begin
    e0 = 8'h00;
    if (cmd_r[0] != CMD_PARK && cmd_r[0] != CMD_REZERO && cmd_r[0] != CMD_CLRBUF && !has_data(cmd_r[0]))
      e0[E0_UNDEF] = 1'b1;
    if ((cmd_r[0] == CMD_READ || cmd_r[0] == CMD_WRITE) && (cmd_r[1] & 8'hfc) != 8'h00)
      e0[E0_OPTION] = 1'b1;
    if (cmd_r[0] == CMD_ALLTRK && cmd_r[1] > FUNC_FORMAT)
      e0[E0_OPTION] = 1'b1;
    if (!inited_r)
      e0[E0_INIT] = 1'b1;
    if (e0[E0_UNDEF] || e0[E0_OPTION] || e0[E0_INIT])
      e0[E0_HOSTSW] = 1'b1;
  end

  // Phase machine
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      state_r <= DCPE_INIT;
      cnt_r <= 4'h0;
      dcnt_r <= 16'h0000;
      busy_r <= 1'b1;
      rdy_r <= 1'b1;
      req_r <= 1'b0;
      error_r <= 1'b0;
      inited_r <= 1'b0;
      conf_r <= 2'h0;
      conf_ok_r <= 1'b0;
    end else if (soft_rst) begin
      state_r <= DCPE_INIT;
      cnt_r <= 4'h0;
      busy_r <= 1'b1;
      rdy_r <= 1'b1;
      req_r <= 1'b0;
      error_r <= 1'b0;
      inited_r <= 1'b0;
    end else begin
      if (wr && addr == PORT_REQCLR)
        req_r <= 1'b0;
      case (state_r)
        DCPE_INIT: begin
          if (fifo_wr && cnt_r != 4'hf)
            cnt_r <= cnt_r + 4'h1;
          if (kick) begin
            // Bad options or drive count flag init error
            if (params_bad(param_r[PB_OPT], param_r[PB_DRIVES])) begin
              error_r <= 1'b1;
            end else begin
              error_r <= 1'b0;
              inited_r <= 1'b1;
            end
            // Same request wait as a command, so the error report follows a kick
            state_r <= DCPE_CMDREQ;
            req_r <= 1'b1;
            rdy_r <= 1'b0;
            cnt_r <= 4'h0;
          end
        end
        DCPE_IDLE: begin
          busy_r <= 1'b0;
          rdy_r <= 1'b1;
          if (fifo_wr && cnt_r < 4'(CMD_MAX_BYTES))
            cnt_r <= cnt_r + 4'h1;
          if (kick) begin
            busy_r <= 1'b1;
            req_r <= 1'b1;
            rdy_r <= 1'b0;
            cnt_r <= 4'h0;
            error_r <= e0 != 8'h00;
            state_r <= DCPE_CMDREQ;
          end
        end
        DCPE_CMDREQ: begin
          if (kick) begin
            rdy_r <= 1'b1;
            if (has_data(cmd_r[0]) && !error_r) begin
              state_r <= DCPE_DATA;
              dcnt_r <= 16'h0000;
              conf_r <= 2'h0;
              conf_ok_r <= 1'b0;
            end else if (error_r) begin
              cnt_r <= 4'h0;
              state_r <= DCPE_STAT;
            end else begin
              busy_r <= 1'b0;
              state_r <= DCPE_IDLE;
            end
          end
        end
        DCPE_DATA: begin
          // Moves past the end of the block are refused
          if ((fifo_wr || fifo_rd) && dcnt_r < 16'(BLOCK_BYTES))
            dcnt_r <= dcnt_r + 16'h0001;
          if (fifo_wr && cmd_r[0] == CMD_ALLTRK) begin
            conf_r <= conf_r + 2'h1;
            if (conf_r == 2'h2)
              conf_ok_r <= wdata == CONFIRM_2 && conf_ok_r;
            else if (conf_r == 2'h1)
              conf_ok_r <= wdata == CONFIRM_1 && conf_ok_r;
            else if (conf_r == 2'h0)
              conf_ok_r <= wdata == CONFIRM_0;
          end
          if (kick) begin
            req_r <= 1'b1;
            rdy_r <= 1'b0;
            if (cmd_r[0] == CMD_ALLTRK && !(conf_ok_r && conf_r == 2'h3))
              error_r <= 1'b1;
            if (media_err != 8'h00 || drive_err != 8'h00)
              error_r <= 1'b1;
            state_r <= DCPE_DATAREQ;
          end
        end
        DCPE_DATAREQ: begin
          if (kick) begin
            cnt_r <= 4'h0;
            rdy_r <= 1'b1;
            if (error_r)
              state_r <= DCPE_STAT;
            else begin
              busy_r <= 1'b0;
              state_r <= DCPE_IDLE;
            end
          end
        end
        DCPE_STAT: begin
          if (fifo_rd && cnt_r < 4'(ERR_BYTES - 1))
            cnt_r <= cnt_r + 4'h1;
          if (kick) begin
            cnt_r <= 4'h0;
            if (error_r && !inited_r) begin
              // Stay uninitialised; host resends the parameter block from byte 0
              state_r <= DCPE_INIT;
            end else begin
              error_r <= 1'b0;
              busy_r <= 1'b0;
              state_r <= DCPE_IDLE;
            end
          end
        end
        default: state_r <= DCPE_INIT;
      endcase
    end
  end

  // Parameter store, cleared by either reset
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      for (int i = 0; i < PARAM_BYTES; i++)
        param_r[i] <= 8'h00;
    end else if (soft_rst) begin
      for (int i = 0; i < PARAM_BYTES; i++)
        param_r[i] <= 8'h00;
    end else if (state_r == DCPE_INIT && fifo_wr && !inited_r) begin
      param_r[cnt_r] <= wdata;
    end
  end

  // Command byte capture
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      for (int i = 0; i < CMD_MAX_BYTES; i++)
        cmd_r[i] <= 8'h00;
    end else if (soft_rst) begin
      // A stale data command would steer the request wait after a fresh init
      for (int i = 0; i < CMD_MAX_BYTES; i++)
        cmd_r[i] <= 8'h00;
    end else if (state_r == DCPE_IDLE && fifo_wr && cnt_r < 4'(CMD_MAX_BYTES)) begin
      cmd_r[cnt_r[2:0]] <= wdata;
    end
  end

  // Error report bytes; drive side flags latched, set wins until the next accepted command or soft reset
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      for (int i = 0; i < ERR_BYTES; i++)
        err_r[i] <= 8'h00;
    end else if (soft_rst || (state_r == DCPE_IDLE && kick && e0 == 8'h00)) begin
      for (int i = 0; i < ERR_BYTES; i++)
        err_r[i] <= 8'h00;
    end else if (state_r == DCPE_IDLE && kick) begin
      err_r[0] <= e0;
    end else if (state_r == DCPE_INIT && kick) begin
      err_r[0] <= 8'h00;
      err_r[0][E0_INIT] <= params_bad(param_r[PB_OPT], param_r[PB_DRIVES]);
      err_r[0][E0_HOSTSW] <= params_bad(param_r[PB_OPT], param_r[PB_DRIVES]);
    end else if (state_r == DCPE_DATA && kick) begin
      err_r[1] <= err_r[1] | media_err;
      err_r[2] <= err_r[2] | (drive_err & 8'h9f);
      // Missing confirmation is a host fault, so the summary bit goes with it
      if (cmd_r[0] == CMD_ALLTRK && !(conf_ok_r && conf_r == 2'h3)) begin
        err_r[0][E0_NOCONF] <= 1'b1;
        err_r[0][E0_HOSTSW] <= 1'b1;
      end
      if (media_err != 8'h00)
        err_r[0][E0_FATAL] <= 1'b1;
    end
  end

  // Read data, one cycle after the strobe
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      rdata <= 8'h00;
    end else if (rd && addr == PORT_STATUS) begin
      rdata <= {req_r, busy_r, rdy_r, error_r, 4'h0};
    end else if (fifo_rd && state_r == DCPE_STAT) begin
      rdata <= err_r[cnt_r];
    end else if (fifo_rd && state_r == DCPE_DATA && dcnt_r < 16'(BLOCK_BYTES)) begin
      rdata <= rdata_in;
    end else begin
      rdata <= 8'h00;
    end
  end

  // Address decode per addressing mode
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      cmd_code <= 8'h00;
      cmd_go <= 1'b0;
      cmd_opts <= 8'h00;
      op_drive <= 8'h00;
      op_cyl <= 16'h0000;
      op_head <= 8'h00;
      op_block <= 24'h000000;
      mode_opts <= 8'h00;
      wdata_vld <= 1'b0;
      wdata_out <= 8'h00;
    end else begin
      cmd_go <= state_r == DCPE_IDLE && kick && e0 == 8'h00;
      cmd_code <= cmd_r[0];
      cmd_opts <= cmd_r[1];
      mode_opts <= param_r[PB_OPT];
      wdata_vld <= state_r == DCPE_DATA && fifo_wr && cmd_r[0] == CMD_WRITE &&
                   dcnt_r < 16'(BLOCK_BYTES);
      wdata_out <= wdata;
      if (!param_r[PB_OPT][OPT_LOGTRK]) begin
        op_drive <= cmd_r[2];
        op_cyl <= {cmd_r[4], cmd_r[3]};
        op_head <= cmd_r[5];
        op_block <= {16'h0000, cmd_r[6]};
      end else if (!param_r[PB_OPT][OPT_LOGDRV]) begin
        op_drive <= {4'h0, cmd_r[2][7:4]};
        op_cyl <= 16'h0000;
        op_head <= 8'h00;
        op_block <= {4'h0, cmd_r[2][3:0], cmd_r[3], cmd_r[4]};
      end else begin
        op_drive <= 8'h00;
        op_cyl <= 16'h0000;
        op_head <= 8'h00;
        op_block <= {cmd_r[2], cmd_r[3], cmd_r[4]};
      end
    end
  end

  // Assertions
  AST_STATUS_LOW: assert property (@(posedge mclk) disable iff (!rstn)
    $past(rd) && $past(addr) == PORT_STATUS |-> rdata[3:0] == 4'h0) else $error("status low bits set");
  AST_SOFT_RESET: assert property (@(posedge mclk) disable iff (!rstn)
    soft_rst |=> state_r == DCPE_INIT && !inited_r) else $error("soft reset kept parameters");
  AST_REQ_RAISE: assert property (@(posedge mclk) disable iff (!rstn)
    state_r == DCPE_IDLE && kick |=> req_r && busy_r) else $error("no request after command");
  AST_NODATA_ERR: assert property (@(posedge mclk) disable iff (!rstn)
    state_r == DCPE_CMDREQ && kick && error_r && !soft_rst |=> state_r != DCPE_DATA) else $error("data on error");
  AST_STAT_ON_ERR: assert property (@(posedge mclk) disable iff (!rstn)
    state_r == DCPE_DATAREQ && kick && error_r && !soft_rst |=> state_r == DCPE_STAT) else $error("no status phase");
  AST_ERR_CNT: assert property (@(posedge mclk) disable iff (!rstn)
    cnt_r < 4'(ERR_BYTES) || state_r != DCPE_STAT) else $error("error index overflow");
  AST_UNDEF: assert property (@(posedge mclk) disable iff (!rstn)
    state_r == DCPE_IDLE && kick && e0[E0_UNDEF] && !soft_rst |=> err_r[0][E0_UNDEF] && error_r)
    else $error("undefined command not flagged");
  AST_INIT_ERR: assert property (@(posedge mclk) disable iff (!rstn)
    state_r == DCPE_INIT && kick && param_r[PB_DRIVES] == 8'h00 && !soft_rst |=> error_r)
    else $error("bad drive count accepted");
  AST_RDY_LOW: assert property (@(posedge mclk) disable iff (!rstn)
    kick && (state_r == DCPE_INIT || state_r == DCPE_IDLE || state_r == DCPE_DATA) |=> req_r && !rdy_r)
    else $error("ready kept during work");
  AST_RDY_STAT: assert property (@(posedge mclk) disable iff (!rstn)
    state_r == DCPE_STAT |-> rdy_r) else $error("error report without ready");
  AST_REQ_CLEAR: assert property (@(posedge mclk) disable iff (!rstn)
    wr && addr == PORT_REQCLR |=> !req_r) else $error("request not cleared");
  AST_NOCONF: assert property (@(posedge mclk) disable iff (!rstn)
    state_r == DCPE_DATA && kick && cmd_r[0] == CMD_ALLTRK && !(conf_ok_r && conf_r == 2'h3)
    |=> error_r && err_r[0][E0_NOCONF] && err_r[0][E0_HOSTSW])
    else $error("missing confirmation not flagged");
  AST_DRV_MASK: assert property (@(posedge mclk) disable iff (!rstn)
    err_r[2][6:5] == 2'h0) else $error("spare drive flags reported");
  AST_BLOCK_CNT: assert property (@(posedge mclk) disable iff (!rstn)
    dcnt_r <= 16'(BLOCK_BYTES)) else $error("block count overrun");
endmodule

// *** design/dcpe_pkg.sv ***
// Constants for the disk command protocol engine.
// Assumes a single clock domain and byte-wide host ports.
package dcpe_pkg;
  // Host port indices
  localparam logic [1:0] PORT_STATUS = 2'h0;
  localparam logic [1:0] PORT_FIFO = 2'h1;
  localparam logic [1:0] PORT_KICK = 2'h2;
  localparam logic [1:0] PORT_REQCLR = 2'h3;
  // Status byte bit positions
  localparam int ST_ERR = 4;
  localparam int ST_RDY = 5;
  localparam int ST_BUSY = 6;
  localparam int ST_REQ = 7;
  // Parameter block
  localparam int PARAM_BYTES = 16;
  localparam logic [3:0] PB_OPT = 4'h1;
  localparam logic [3:0] PB_DRIVES = 4'h2;
  localparam logic [3:0] PB_CYL_LO = 4'h3;
  localparam logic [3:0] PB_CYL_HI = 4'h4;
  localparam logic [3:0] PB_HEADS = 4'h5;
  localparam logic [3:0] PB_BLK_LO = 4'h6;
  localparam logic [3:0] PB_BLK_HI = 4'h7;
  // Option flag bits
  localparam int OPT_DEBLOCK = 0;
  localparam int OPT_LOGTRK = 1;
  localparam int OPT_LOGDRV = 2;
  localparam int OPT_VERIFY = 3;
  localparam logic [7:0] OPT_RSVD_MASK = 8'hf0;
  // Command codes
  localparam logic [7:0] CMD_PARK = 8'h00;
  localparam logic [7:0] CMD_REZERO = 8'h01;
  localparam logic [7:0] CMD_CLRBUF = 8'h02;
  localparam logic [7:0] CMD_ALLTRK = 8'h04;
  localparam logic [7:0] CMD_READ = 8'h08;
  localparam logic [7:0] CMD_WRITE = 8'h0a;
  localparam int CMD_MAX_BYTES = 7;
  localparam int ALLTRK_BYTES = 3;
  localparam logic [7:0] FUNC_FORMAT = 8'h01;
  localparam logic [7:0] CONFIRM_0 = 8'h59;
  localparam logic [7:0] CONFIRM_1 = 8'h45;
  localparam logic [7:0] CONFIRM_2 = 8'h53;
  // Error report
  localparam int ERR_BYTES = 13;
  localparam int E0_FATAL = 0;
  localparam int E0_HOSTSW = 2;
  localparam int E0_INIT = 3;
  localparam int E0_OPTION = 4;
  localparam int E0_UNDEF = 5;
  localparam int E0_NOCONF = 6;
  localparam int E0_ADDR = 7;
  // Drive constants
  localparam int SECTOR_BYTES = 512;
  localparam int SECTORS_PER_TRACK = 16;
  localparam logic [7:0] FILL_INIT = 8'he5;
  localparam logic [7:0] FILL_GAP = 8'hb6;
  localparam int MAX_RETRIES = 10;
  // Phase machine
  typedef enum logic [5:0] {
    DCPE_INIT = 6'b000001,
    DCPE_IDLE = 6'b000010,
    DCPE_CMDREQ = 6'b000100,
    DCPE_DATA = 6'b001000,
    DCPE_DATAREQ = 6'b010000,
    DCPE_STAT = 6'b100000
  } dcpe_state_e;
endpackage

// *** tb/dcpe_drive_model.sv ***
// Drive-side model facing the engine: read bytes, media and drive flags.
// Assumes one clock; the bench raises fault to inject drive errors.
`timescale 1ns/10ps
module dcpe_drive_model
  import dcpe_pkg::*;
(
  // Clock and reset
  input wire logic mclk,
  input wire logic rstn,
  // Host port activity seen by the drive side
  input wire logic [1:0] addr,
  input wire logic rd,
  input wire logic fault,
  // Towards the engine
  output logic [7:0] media_err,
  output logic [7:0] drive_err,
  output logic [7:0] rdata_in
);
  logic [7:0] pat_r;
  // Off a read the line shows the inverse, so a stale byte cannot pass
  assign rdata_in = (rd && addr == PORT_FIFO) ? pat_r : ~pat_r;
  assign media_err = fault ? 8'h04 : 8'h00;
  // Spare bits 5 and 6 are set so their masking shows
  assign drive_err = fault ? 8'h62 : 8'h00;
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      pat_r <= 8'ha0;
    end else if (rd && addr == PORT_FIFO) begin
      pat_r <= pat_r + 8'h01;
    end
  end
endmodule

// *** tb/dcpe_engine_test.sv ***
// Self-checking bench for the protocol engine: phases, decode, error report.
// Assumes the drive-side model and a shortened block length.
`timescale 1ns/10ps
module dcpe_engine_test;
  import dcpe_pkg::*;
  localparam int BLK = 4;
  typedef struct packed {
    logic [7:0] opt;
    logic [55:0] cmd;
    logic [3:0] n;
    logic [1:0] dir;
    logic [7:0] drv;
    logic [15:0] cyl;
    logic [7:0] head;
    logic [23:0] blk;
  } dcpe_row_s;
  logic mclk, rstn, wr, rd, cmd_go, wdata_vld, fault;
  logic [1:0] addr;
  logic [7:0] wdata, rdata, cmd_code, cmd_opts, op_drive, op_head, mode_opts, wdata_out;
  logic [7:0] media_err, drive_err, rdata_in, exp_pat, cur_opt;
  logic [15:0] op_cyl;
  logic [23:0] op_block;
  int mismatches, checked;
  dcpe_row_s rows [7] = '{
    '{8'h00, 56'h00, 4'd1, 2'd0, 8'h00, 16'h0, 8'h00, 24'h0},
    '{8'h00, 56'h01, 4'd1, 2'd0, 8'h00, 16'h0, 8'h00, 24'h0},
    '{8'h00, 56'h02, 4'd1, 2'd0, 8'h00, 16'h0, 8'h00, 24'h0},
    '{8'h00, 56'h08000134120507, 4'd7, 2'd1, 8'h01, 16'h1234, 8'h05, 24'h000007},
    '{8'h00, 56'h0a030078560207, 4'd7, 2'd2, 8'h00, 16'h5678, 8'h02, 24'h000007},
    '{8'h03, 56'h08003abcde0000, 4'd7, 2'd1, 8'h03, 16'h0, 8'h00, 24'h0abcde},
    '{8'h0e, 56'h0a003abcde0000, 4'd7, 2'd2, 8'h00, 16'h0, 8'h00, 24'h3abcde}};

  dcpe_engine #(.BLOCK_BYTES(BLK)) u_dut (.mclk(mclk), .rstn(rstn), .addr(addr), .wdata(wdata), .wr(wr),
    .rd(rd), .rdata(rdata), .cmd_code(cmd_code), .cmd_go(cmd_go), .cmd_opts(cmd_opts), .op_drive(op_drive),
    .op_cyl(op_cyl), .op_head(op_head), .op_block(op_block), .mode_opts(mode_opts), .wdata_vld(wdata_vld),
    .wdata_out(wdata_out), .media_err(media_err), .drive_err(drive_err), .rdata_in(rdata_in));
  dcpe_drive_model u_drv (.mclk(mclk), .rstn(rstn), .addr(addr), .rd(rd), .fault(fault),
    .media_err(media_err), .drive_err(drive_err), .rdata_in(rdata_in));

  always #12.5 mclk = ~mclk;

  task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
    checked++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected %s: expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic chk_w(input string nm, input logic [23:0] exp, input logic [23:0] got);
    checked++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected %s: expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic wr_b(input logic [1:0] a, input logic [7:0] d);
    @(posedge mclk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge mclk);
    wr <= 1'b0;
    #1;
  endtask
  task automatic rd_b(input logic [1:0] a, output logic [7:0] v);
    @(posedge mclk);
    addr <= a;
    rd <= 1'b1;
    @(posedge mclk);
    rd <= 1'b0;
    #1;
    v = rdata;
    if (a == PORT_FIFO) exp_pat++;
  endtask
  task automatic chk_st(input logic [7:0] exp);
    logic [7:0] v;
    rd_b(PORT_STATUS, v);
    chk("status", exp, v);
  endtask
  task automatic send(input logic [55:0] c, input int n);
    for (int i = 0; i < n; i++) wr_b(PORT_FIFO, c[55-8*i -: 8]);
    wr_b(PORT_KICK, 8'h00);
  endtask
  // Kicks into the status phase, then reads the whole report
  task automatic err_rd(input logic k0, input logic [7:0] e0, input logic [7:0] e1, input logic [7:0] e2);
    logic [7:0] v [ERR_BYTES];
    wr_b(PORT_KICK, 8'h00);
    for (int i = 0; i < ERR_BYTES; i++) rd_b(PORT_FIFO, v[i]);
    if (k0) chk("err byte0", e0, v[0]);
    chk("err byte1", e1, v[1]);
    chk("err byte2", e2, v[2]);
    chk("err byte3", 8'h00, v[3]);
  endtask
  task automatic init(input logic [7:0] opt, input logic [7:0] drv, input logic bad);
    logic [7:0] pb [PARAM_BYTES];
    pb = '{8'h40, opt, drv, 8'h00, 8'h02, 8'h04, 8'h00, 8'h02, 8'hf8, 8'h03, 8'hf8, 8'h02, 8'h09, 8'h01,
      8'h00, 8'h01};
    wr_b(PORT_STATUS, 8'h00);
    for (int i = 0; i < PARAM_BYTES; i++) wr_b(PORT_FIFO, pb[i]);
    wr_b(PORT_KICK, 8'h00);
    chk_st({3'b110, bad, 4'h0});
    wr_b(PORT_REQCLR, 8'h00);
    if (bad) err_rd(1'b1, 8'h0c, 8'h00, 8'h00);
    wr_b(PORT_KICK, 8'h00);
    if (!bad) chk_st(8'h20);
    if (!bad) chk("mode_opts", opt, mode_opts);
    cur_opt = opt;
  endtask
  task automatic run_row(input dcpe_row_s r);
    logic [7:0] v;
    send(r.cmd, int'(r.n));
    chk("cmd_go", 8'h01, {7'h0, cmd_go});
    chk("cmd_code", r.cmd[55:48], cmd_code);
    chk_st(8'hc0);
    if (r.dir != 2'd0) begin
      chk("cmd_opts", r.cmd[47:40], cmd_opts);
      chk_w("op_block", r.blk, op_block);
      if (!r.opt[OPT_LOGTRK]) chk_w("op_cyl", {8'h00, r.cyl}, {8'h00, op_cyl});
      if (!r.opt[OPT_LOGTRK]) chk("op_head", r.head, op_head);
      if (!r.opt[OPT_LOGDRV]) chk("op_drive", r.drv, op_drive);
    end
    wr_b(PORT_REQCLR, 8'h00);
    wr_b(PORT_KICK, 8'h00);
    if (r.dir != 2'd0) begin
      rd_b(PORT_STATUS, v);
      chk("ready", 8'h20, v & 8'h20);
      for (int i = 0; i < BLK; i++) begin
        if (r.dir == 2'd1) begin
          chk("read byte", exp_pat, ~rdata_in);
          rd_b(PORT_FIFO, v);
          chk("read data", exp_pat - 8'h01, v);
        end else begin
          wr_b(PORT_FIFO, 8'h30 + 8'(i));
          chk("wdata_vld", 8'h01, {7'h0, wdata_vld});
          chk("wdata_out", 8'h30 + 8'(i), wdata_out);
        end
      end
      wr_b(PORT_KICK, 8'h00);
      chk_st(8'hc0);
      wr_b(PORT_REQCLR, 8'h00);
      wr_b(PORT_KICK, 8'h00);
    end
    chk_st(8'h20);
  endtask
  task automatic alltrk(input logic [23:0] word, input logic [7:0] e0);
    send(56'h04010000000000, ALLTRK_BYTES);
    chk_st(8'hc0);
    wr_b(PORT_REQCLR, 8'h00);
    wr_b(PORT_KICK, 8'h00);
    for (int i = 0; i < 3; i++) wr_b(PORT_FIFO, word[23-8*i -: 8]);
    wr_b(PORT_KICK, 8'h00);
    chk_st({3'b110, e0 != 8'h00, 4'h0});
    wr_b(PORT_REQCLR, 8'h00);
    if (e0 != 8'h00) err_rd(1'b1, e0, 8'h00, 8'h00);
    wr_b(PORT_KICK, 8'h00);
    chk_st(8'h20);
  endtask
  task automatic bad_cmd(input logic [55:0] c, input int n, input logic [7:0] e0);
    send(c, n);
    chk("cmd_go", 8'h00, {7'h0, cmd_go});
    chk_st(8'hd0);
    wr_b(PORT_REQCLR, 8'h00);
    err_rd(1'b1, e0, 8'h00, 8'h00);
    wr_b(PORT_KICK, 8'h00);
  endtask
  task automatic results();
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  initial begin
    repeat (30000) @(posedge mclk);
    mismatches++;
    results();
  end

  initial begin
    mclk = 1'b0;
    rstn = 1'b0;
    addr = 2'h0;
    wdata = 8'h00;
    wr = 1'b0;
    rd = 1'b0;
    fault = 1'b0;
    exp_pat = 8'ha0;
    cur_opt = 8'hff;
    mismatches = 0;
    checked = 0;
    repeat (2) @(posedge mclk);
    rstn <= 1'b1;
    #1;
    chk("rdata idle", 8'h00, rdata);
    chk_st(8'h60);
    init(8'h00, 8'h03, 1'b1);
    init(8'h10, 8'h01, 1'b1);
    foreach (rows[i]) begin
      if (rows[i].opt !== cur_opt) init(rows[i].opt, 8'h02, 1'b0);
      run_row(rows[i]);
    end
    init(8'h00, 8'h01, 1'b0);
    bad_cmd(56'h03000000000000, 1, 8'h24);
    chk_st(8'h20);
    bad_cmd(56'h08040000000000, 7, 8'h14);
    chk_st(8'h20);
    alltrk(24'h594553, 8'h00);
    alltrk(24'h594558, 8'h44);
    fault <= 1'b1;
    send(56'h0a000000000001, 7);
    wr_b(PORT_REQCLR, 8'h00);
    wr_b(PORT_KICK, 8'h00);
    for (int i = 0; i < BLK; i++) wr_b(PORT_FIFO, 8'h55);
    wr_b(PORT_KICK, 8'h00);
    chk_st(8'hd0);
    wr_b(PORT_REQCLR, 8'h00);
    // Spare bits of the drive flags must not reach the report
    err_rd(1'b0, 8'h00, 8'h04, 8'h02);
    wr_b(PORT_KICK, 8'h00);
    fault <= 1'b0;
    wr_b(PORT_STATUS, 8'h00);
    chk_st(8'h60);
    chk("mode_opts", 8'h00, mode_opts);
    bad_cmd(56'h02000000000000, 1, 8'h0c);
    @(posedge mclk);
    rstn <= 1'b0;
    @(posedge mclk);
    rstn <= 1'b1;
    #1;
    chk_st(8'h60);
    results();
  end
endmodule
